// [hw/mmp_regs.svh]
// Register offsets, field positions, reset values and timing figures.
`ifndef MMP_REGS_SVH
`define MMP_REGS_SVH
`define MMP_ADDR_W 32
`define MMP_OFS_CTRL 8'h00
`define MMP_OFS_STATUS 8'h04
`define MMP_OFS_CAP1 8'h08
`define MMP_OFS_CAP2 8'h0C
`define MMP_OFS_CHIP 8'h10
`define MMP_OFS_DIMM 8'h14
`define MMP_OFS_CORR 8'h18
`define MMP_CTRL_MIRROR 0
`define MMP_CTRL_RESTART 1
`define MMP_CTRL_SCRUB 2
`define MMP_CAP_RESET 32'h0000_0000
`define MMP_CLK_PERIOD_NS 100
`define MMP_RECOPY_S_PER_GB 6
`define MMP_WORD_BYTES 8
`define MMP_GB_BYTES 64'h0000_0000_4000_0000
`define MMP_BLINK_HALF_MS 500
`define MMP_SCRUB_GAP_CYC 64
`define MMP_TEST_WORDS 4
`define MMP_TEST_PATTERN 64'hA5A5_5A5A_C3C3_3C3C
`endif

// [hw/mmp_pkg.sv]
// Types shared by the mirrored memory port controller.
package mmp_pkg;
  `include "mmp_regs.svh"

  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] check;
    logic [63:0] data;
  } mmp_word_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`MMP_ADDR_W-1:0] addr;
    mmp_word_type word;
  } mmp_preq_type;

  typedef struct packed {
    logic valid;
    mmp_word_type word;
  } mmp_presp_type;

  typedef struct packed {
    logic [5:0] syn;
    logic [63:0] data;
  } mmp_dec_type;

  typedef enum logic [1:0] {PS_ONLINE, PS_DOWN, PS_TEST, PS_RECOPY}
    mmp_pstate_type;
  typedef enum logic [1:0] {EN_IDLE, EN_BUSY, EN_DONE} mmp_eng_type;
  typedef enum logic [2:0] {OP_HOST_RD, OP_HOST_WR, OP_SCRUB_RD,
    OP_SCRUB_WB, OP_TEST_WR, OP_TEST_RD, OP_COPY_RD, OP_COPY_WR}
    mmp_op_type;

  typedef struct packed {
    logic mirror_cfg;
    logic mirror_act;
    logic scrub_en;
    logic [`MMP_ADDR_W-1:0] cap1;
    logic [`MMP_ADDR_W-1:0] cap2;
    logic [31:0] corr_cnt;
    logic [1:0] pwr;
    logic [1:0] pwr_led;
    logic [1:0] hp_led;
    mmp_pstate_type [1:0] pst;
    logic [1:0] offline;
    logic [1:0] steer_ok;
    logic [1:0][4:0] steer_chip;
    logic [1:0][4:0] second_chip;
    logic [1:0][1:0] fails;
    logic [15:0] dimm_led;
    logic predictive_failure_alert;
    logic [1:0] door_prev;
    logic [31:0] blink_cnt;
    logic blink;
    mmp_eng_type eng;
    mmp_op_type op;
    logic [1:0] rd_wait;
    logic lost;
    logic rport;
    mmp_word_type rword;
    logic [`MMP_ADDR_W-1:0] addr;
    logic [`MMP_ADDR_W-1:0] scrub_addr;
    logic scrub_port;
    logic [15:0] scrub_gap;
    logic [`MMP_ADDR_W-1:0] copy_addr;
    logic [15:0] pace;
    logic [7:0] test_idx;
    mmp_preq_type [1:0] preq;
    logic host_ack;
    logic host_err;
    logic [63:0] host_rdata;
    logic waitreq;
    logic [31:0] rdata;
  } mmp_state_type;
endpackage : mmp_pkg

// [hw/mmp_controller.sv]
// Mirrored two-port memory controller reliability logic.
// Summary of operation
// - Two memory ports; sockets 1-8 on port one, 9-16 on port two.
// - Accesses interleave four ways; sockets fill in equal groups of four.
// - Each port moves one 8-byte word per transfer toward the buffers.
// - Mirroring is off at reset; the setting applies at the next restart.
// - Mirrored: host sees port-one capacity; writes go to both ports.
// - Unequal ports: only addresses below port-two capacity are mirrored.
// - Failed socket while mirrored: reads go to other port, socket lamp lit.
// - Door opened: port power off, power and hot-plug lamps off.
// - Door closed: power and lamp on, socket test, socket lamps cleared.
// - After test, recopy at 6 s/GB; hot-plug lamp blinks meanwhile.
// - Recopy done: hot-plug lamp steady, full mirrored operation resumes.
// - Each complex has its own mirroring enable in its own controller.
// - Mirroring pairs only the two ports of this one controller.
// - Word is 64 data bits, 6 check bits and 2 spare bits.
// - First failed chip is steered into spare bits with no alert.
// - Second chip failure raises the alert and lights the socket lamp.
// - A port keeps running through two whole-chip failures.
// - Mirrored third failure: alert, port offline, redundant port serves.
// - Correction repairs repeated single-bit errors of one chip.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module mmp_controller
  import mmp_pkg::*;
#(
  parameter int unsigned SCRUB_GAP = `MMP_SCRUB_GAP_CYC,
  parameter int unsigned TEST_WORDS = `MMP_TEST_WORDS,
  parameter int unsigned BLINK_CYC =
    `MMP_BLINK_HALF_MS * 1000000 / `MMP_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Register bus.
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Host access.
  input wire logic HOST_VALID,
  input wire logic HOST_WRITE,
  input wire logic [`MMP_ADDR_W-1:0] HOST_ADDR,
  input wire logic [63:0] HOST_WDATA,
  output logic HOST_ACK,
  output logic HOST_ERR,
  output logic [63:0] HOST_RDATA,
  // Memory ports toward the memory interface buffers.
  output mmp_preq_type [1:0] PORT_REQ,
  input wire logic [1:0] PORT_READY,
  input wire mmp_presp_type [1:0] PORT_RESP,
  // Access doors, power and lamps.
  input wire logic [1:0] DOOR_OPEN,
  output logic [1:0] PORT_POWER,
  output logic [1:0] LED_PORT_POWER,
  output logic [1:0] LED_HOTPLUG,
  output logic [15:0] LED_DIMM_FAIL,
  output logic PREDICTIVE_FAILURE_ALERT
);

  localparam int A = `MMP_ADDR_W;
  // Recopy pacing: least time per word, rounded up, never below a cycle.
  localparam longint CP_NUM = longint'(`MMP_RECOPY_S_PER_GB) *
    longint'(1000000000) * longint'(`MMP_WORD_BYTES);
  localparam longint CP_DEN = longint'(`MMP_GB_BYTES) *
    longint'(`MMP_CLK_PERIOD_NS);
  localparam longint CP_RAW = (CP_NUM + CP_DEN - 1) / CP_DEN;
  localparam logic [15:0] RECOPY_CYC = 16'((CP_RAW < 1) ? 1 : CP_RAW);
  localparam logic [15:0] GAP = 16'(SCRUB_GAP);
  localparam logic [31:0] BLINK = 32'(BLINK_CYC);
  localparam logic [7:0] TWORDS = 8'(TEST_WORDS);

  mmp_state_type s;
  mmp_state_type n;

  // ==========================================================
  // Check bits and spare-bit steering
  // ==========================================================
  // Bit 0 has no syndrome code; six check bits only give 63 codes.
  function automatic logic [5:0] calc_check(input logic [63:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 1; i < 64; i++) begin
      if (d[i]) begin
        c = c ^ 6'(i);
      end
    end
    return c;
  endfunction : calc_check

  function automatic mmp_word_type encode(input logic [63:0] d,
      input logic ok, input logic [4:0] chip);
    mmp_word_type w;
    w.data = d;
    w.check = calc_check(d);
    w.spare = ok ? d[{chip, 1'b0} +: 2] : 2'h0;
    return w;
  endfunction : encode

  function automatic mmp_dec_type decode(input mmp_word_type w,
      input logic ok, input logic [4:0] chip);
    mmp_dec_type r;
    logic [63:0] st;
    r.data = w.data;
    r.syn = w.check ^ calc_check(w.data);
    st = w.data;
    st[{chip, 1'b0} +: 2] = w.spare;
    // Words written before steering began hold no spare copy, so a lone
    // error in the steered chip is still fixed by plain correction.
    if (ok && r.syn != 6'h00 && r.syn[5:1] != chip) begin
      r.data = st;
      r.syn = w.check ^ calc_check(st);
    end
    if (r.syn != 6'h00) begin
      r.data[r.syn] = ~r.data[r.syn];
    end
    return r;
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin : next_state
    logic [1:0] insv;
    logic [1:0] wok;
    logic [1:0] tgt;
    logic hit;
    logic rep;
    logic sp;
    logic [A-1:0] la;
    logic [A-1:0] lim;
    logic launch;
    mmp_op_type lop;
    logic [1:0] ltgt;
    logic [A-1:0] laddr;
    logic [63:0] ldata;
    mmp_dec_type dec;
    logic [3:0] dimm;
    logic [31:0] regv;
    logic known;
    logic lst;
    insv = 2'b00;
    wok = 2'b00;
    tgt = 2'b00;
    hit = 1'b0;
    la = '0;
    lim = '0;
    launch = 1'b0;
    lop = OP_HOST_RD;
    ltgt = 2'b00;
    laddr = '0;
    ldata = 64'h0;
    dec = '0;
    dimm = 4'h0;
    regv = 32'h0;
    known = 1'b0;
    lst = 1'b0;
    rep = 1'b0;
    sp = 1'b0;
    n = s;
    n.host_ack = 1'b0;
    n.host_err = 1'b0;
    n.predictive_failure_alert = 1'b0;
    n.door_prev = DOOR_OPEN;
    for (int p = 0; p < 2; p++) begin
      insv[p] = s.pwr[p] && !s.offline[p] && s.pst[p] == PS_ONLINE;
    end
    rep = !(s.pst[0] == PS_TEST || s.pst[0] == PS_RECOPY);
    sp = s.scrub_port;

    // ========================================================
    // Register bus slave, one wait state per access
    // ========================================================
    if ((AVS_READ || AVS_WRITE) && s.waitreq) begin
      n.waitreq = 1'b0;
      unique case (AVS_ADDRESS)
        `MMP_OFS_CTRL: regv = {29'h0, s.scrub_en, 1'b0, s.mirror_cfg};
        `MMP_OFS_STATUS: regv = {22'h0, s.pst[1], s.pst[0], s.offline,
          s.pwr, s.blink, s.mirror_act};
        `MMP_OFS_CAP1: regv = 32'(s.cap1);
        `MMP_OFS_CAP2: regv = 32'(s.cap2);
        `MMP_OFS_CHIP: regv = {16'h0, s.steer_ok[1], s.steer_chip[1],
          s.fails[1], s.steer_ok[0], s.steer_chip[0], s.fails[0]};
        `MMP_OFS_DIMM: regv = {16'h0, s.dimm_led};
        `MMP_OFS_CORR: regv = s.corr_cnt;
        default: regv = 32'h0;
      endcase
      n.rdata = regv;
    end else begin
      n.waitreq = 1'b1;
    end
    if (AVS_WRITE && !s.waitreq) begin
      unique case (AVS_ADDRESS)
        `MMP_OFS_CTRL: begin
          if (AVS_BYTEENABLE[0]) begin
            n.mirror_cfg = AVS_WRITEDATA[`MMP_CTRL_MIRROR];
            n.scrub_en = AVS_WRITEDATA[`MMP_CTRL_SCRUB];
            if (AVS_WRITEDATA[`MMP_CTRL_RESTART]) begin
              n.mirror_act = n.mirror_cfg;
            end
          end
        end
        `MMP_OFS_CAP1: n.cap1 = A'(merge(32'(s.cap1), AVS_WRITEDATA,
          AVS_BYTEENABLE));
        `MMP_OFS_CAP2: n.cap2 = A'(merge(32'(s.cap2), AVS_WRITEDATA,
          AVS_BYTEENABLE));
        default: ;
      endcase
    end

    // ========================================================
    // Blink timer, doors and lamps
    // ========================================================
    if (s.blink_cnt >= BLINK - 32'h1) begin
      n.blink_cnt = 32'h0;
      n.blink = !s.blink;
    end else begin
      n.blink_cnt = s.blink_cnt + 32'h1;
    end
    if (s.pace != 16'h0) begin
      n.pace = s.pace - 16'h1;
    end
    if (s.scrub_gap != 16'h0) begin
      n.scrub_gap = s.scrub_gap - 16'h1;
    end
    for (int p = 0; p < 2; p++) begin
      if (DOOR_OPEN[p] && !s.door_prev[p]) begin
        n.pwr[p] = 1'b0;
        n.pwr_led[p] = 1'b0;
        n.pst[p] = PS_DOWN;
        n.preq[p].valid = 1'b0;
        if (s.rd_wait[p]) begin
          n.lost = 1'b1;
        end
        n.rd_wait[p] = 1'b0;
      end else if (!DOOR_OPEN[p] && s.door_prev[p]) begin
        n.pwr[p] = 1'b1;
        n.pwr_led[p] = 1'b1;
        n.pst[p] = PS_TEST;
        n.test_idx = 8'h0;
        n.dimm_led[8*p +: 8] = 8'h00;
        n.fails[p] = 2'h0;
        n.steer_ok[p] = 1'b0;
        n.offline[p] = 1'b0;
      end
    end

    // ========================================================
    // Access engine
    // ========================================================
    unique case (s.eng)
      EN_IDLE: begin
        if (HOST_VALID) begin
          if (s.mirror_act) begin
            hit = HOST_ADDR < s.cap1;
            la = HOST_ADDR;
          end else if (HOST_ADDR < s.cap1) begin
            hit = 1'b1;
            la = HOST_ADDR;
            tgt = 2'b01;
          end else begin
            la = HOST_ADDR - s.cap1;
            hit = la < s.cap2;
            tgt = 2'b10;
          end
          for (int p = 0; p < 2; p++) begin
            wok[p] = insv[p] || (s.pst[p] == PS_RECOPY &&
              la < s.copy_addr);
          end
          if (s.mirror_act) begin
            if (HOST_WRITE) begin
              tgt = {la < s.cap2 && wok[1], wok[0]};
            end else if (insv[0]) begin
              tgt = 2'b01;
            end else begin
              tgt = {la < s.cap2 && insv[1], 1'b0};
            end
          end else begin
            tgt = tgt & (HOST_WRITE ? wok : insv);
          end
          if (!hit || tgt == 2'b00) begin
            n.host_err = 1'b1;
            n.host_ack = 1'b1;
            n.eng = EN_DONE;
          end else begin
            launch = 1'b1;
            lop = HOST_WRITE ? OP_HOST_WR : OP_HOST_RD;
            ltgt = tgt;
            laddr = la;
            ldata = HOST_WDATA;
          end
        end else if (s.pst[rep] == PS_TEST) begin
          launch = 1'b1;
          lop = OP_TEST_WR;
          ltgt = rep ? 2'b10 : 2'b01;
          laddr = A'(s.test_idx);
          ldata = `MMP_TEST_PATTERN ^ 64'(s.test_idx);
        end else if (s.pst[rep] == PS_RECOPY) begin
          if (s.copy_addr >= s.cap2 || !insv[!rep]) begin
            n.pst[rep] = PS_ONLINE;
          end else if (s.pace == 16'h0) begin
            launch = 1'b1;
            lop = OP_COPY_RD;
            ltgt = rep ? 2'b01 : 2'b10;
            laddr = s.copy_addr;
          end
        end else if (s.scrub_en && s.scrub_gap == 16'h0) begin
          lim = sp ? s.cap2 : s.cap1;
          if (!insv[sp] || s.scrub_addr >= lim) begin
            n.scrub_port = !sp;
            n.scrub_addr = '0;
          end else begin
            launch = 1'b1;
            lop = OP_SCRUB_RD;
            ltgt = sp ? 2'b10 : 2'b01;
            laddr = s.scrub_addr;
          end
        end
      end
      EN_BUSY: begin
        for (int p = 0; p < 2; p++) begin
          if (s.preq[p].valid && PORT_READY[p]) begin
            n.preq[p].valid = 1'b0;
          end
          if (s.rd_wait[p] && PORT_RESP[p].valid) begin
            n.rd_wait[p] = 1'b0;
            n.rword = PORT_RESP[p].word;
          end
        end
        if (!n.preq[0].valid && !n.preq[1].valid && n.rd_wait == 2'b00)
        begin
          dec = decode(n.rword, s.steer_ok[s.rport],
            s.steer_chip[s.rport]);
          lst = n.lost;
          n.eng = EN_IDLE;
          n.lost = 1'b0;
          unique case (s.op)
            OP_HOST_RD, OP_HOST_WR: begin
              if (s.op == OP_HOST_RD) begin
                n.host_rdata = dec.data;
              end
              n.host_err = lst;
              n.host_ack = 1'b1;
              n.eng = EN_DONE;
            end
            OP_SCRUB_RD: begin
              if (lst || dec.syn == 6'h00) begin
                n.scrub_addr = s.scrub_addr + A'(1);
                n.scrub_gap = GAP;
              end else begin
                n.corr_cnt = s.corr_cnt + 32'h1;
                lim = s.rport ? s.cap2 : s.cap1;
                dimm = {s.rport, s.addr >= (lim >> 1),
                  s.addr[1:0]};
                known = (s.steer_ok[s.rport] &&
                    dec.syn[5:1] == s.steer_chip[s.rport]) ||
                  (s.fails[s.rport] >= 2'h2 &&
                    dec.syn[5:1] == s.second_chip[s.rport]);
                if (!known) begin
                  unique case (s.fails[s.rport])
                    2'h0: begin
                      n.steer_ok[s.rport] = 1'b1;
                      n.steer_chip[s.rport] = dec.syn[5:1];
                      n.fails[s.rport] = 2'h1;
                    end
                    2'h1: begin
                      n.predictive_failure_alert = 1'b1;
                      n.second_chip[s.rport] = dec.syn[5:1];
                      n.dimm_led[dimm] = 1'b1;
                      n.fails[s.rport] = 2'h2;
                    end
                    default: begin
                      n.predictive_failure_alert = 1'b1;
                      n.dimm_led[dimm] = 1'b1;
                      n.fails[s.rport] = 2'h3;
                      if (s.mirror_act) begin
                        n.offline[s.rport] = 1'b1;
                      end
                    end
                  endcase
                end
                launch = 1'b1;
                lop = OP_SCRUB_WB;
                ltgt = s.rport ? 2'b10 : 2'b01;
                laddr = s.addr;
                ldata = dec.data;
              end
            end
            OP_SCRUB_WB: begin
              n.scrub_addr = s.scrub_addr + A'(1);
              n.scrub_gap = GAP;
            end
            OP_TEST_WR: begin
              launch = 1'b1;
              lop = OP_TEST_RD;
              ltgt = s.rport ? 2'b10 : 2'b01;
              laddr = s.addr;
            end
            OP_TEST_RD: begin
              if (s.pst[s.rport] != PS_TEST) begin
                n.test_idx = 8'h0;
              end else if (lst || dec.data !=
                  (`MMP_TEST_PATTERN ^ 64'(s.test_idx))) begin
                n.pst[s.rport] = PS_DOWN;
                n.dimm_led[{s.rport, 1'b0, s.test_idx[1:0]}] = 1'b1;
              end else if (s.test_idx == TWORDS - 8'h1) begin
                n.copy_addr = '0;
                n.pace = 16'h0;
                n.pst[s.rport] = (s.mirror_act && insv[!s.rport]) ?
                  PS_RECOPY : PS_ONLINE;
              end else begin
                n.test_idx = s.test_idx + 8'h1;
              end
            end
            OP_COPY_RD: begin
              if (!lst) begin
                launch = 1'b1;
                lop = OP_COPY_WR;
                ltgt = s.rport ? 2'b01 : 2'b10;
                laddr = s.addr;
                ldata = dec.data;
              end
            end
            OP_COPY_WR: begin
              n.copy_addr = s.copy_addr + A'(1);
              n.pace = RECOPY_CYC - 16'h1;
            end
          endcase
        end
      end
      EN_DONE: n.eng = EN_IDLE;
      default: n.eng = EN_IDLE;
    endcase

    // Start a transfer; write data is encoded with each port's steering.
    if (launch) begin
      n.eng = EN_BUSY;
      n.op = lop;
      n.addr = laddr;
      n.rport = ltgt[1];
      n.lost = 1'b0;
      for (int p = 0; p < 2; p++) begin
        n.preq[p].valid = ltgt[p] && n.pwr[p];
        n.preq[p].write = lop inside {OP_HOST_WR, OP_SCRUB_WB,
          OP_TEST_WR, OP_COPY_WR};
        n.preq[p].addr = laddr;
        n.preq[p].word = encode(ldata, n.steer_ok[p],
          n.steer_chip[p]);
        n.rd_wait[p] = n.preq[p].valid && !n.preq[p].write;
      end
    end

    // Hot-plug lamp: steady when replaceable, blinking while rebuilding.
    for (int p = 0; p < 2; p++) begin
      unique case (n.pst[p])
        PS_ONLINE: n.hp_led[p] = s.mirror_act;
        PS_DOWN: n.hp_led[p] = 1'b0;
        default: n.hp_led[p] = n.blink;
      endcase
    end

    if (RESET) begin
      n = '0;
      n.waitreq = 1'b1;
      n.pwr = 2'b11;
      n.pwr_led = 2'b11;
      n.cap1 = `MMP_CAP_RESET;
      n.cap2 = `MMP_CAP_RESET;
    end
  end

  // ==========================================================
  // State register and outputs
  // ==========================================================
  always_ff @(posedge CLK) begin
    s <= n;
  end

  assign AVS_READDATA = s.rdata;
  assign AVS_WAITREQUEST = s.waitreq;
  assign HOST_ACK = s.host_ack;
  assign HOST_ERR = s.host_err;
  assign HOST_RDATA = s.host_rdata;
  assign PORT_REQ = s.preq;
  assign PORT_POWER = s.pwr;
  assign LED_PORT_POWER = s.pwr_led;
  assign LED_HOTPLUG = s.hp_led;
  assign LED_DIMM_FAIL = s.dimm_led;
  assign PREDICTIVE_FAILURE_ALERT = s.predictive_failure_alert;

endmodule : mmp_controller

// [testbench/mmp_properties.sv]
// Port-level checks for the mirrored memory port controller.
`timescale 1ns/1ps
module mmp_properties
  import mmp_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Watched ports.
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic HOST_ACK,
  input wire logic HOST_ERR,
  input wire mmp_preq_type [1:0] PORT_REQ,
  input wire logic [1:0] PORT_READY,
  input wire logic [1:0] DOOR_OPEN,
  input wire logic [1:0] PORT_POWER,
  input wire logic [1:0] LED_PORT_POWER,
  input wire logic [1:0] LED_HOTPLUG,
  input wire logic [15:0] LED_DIMM_FAIL,
  input wire logic PREDICTIVE_FAILURE_ALERT
);
  // ==========
  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Data bit 0 is left out of the check bits, so it is skipped here too.
  function automatic logic [5:0] chk(logic [63:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 1; i < 64; i++)
      c ^= d[i] ? 6'(i) : 6'h00;
    return c;
  endfunction : chk
  a_bus_one_wait:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus wait");
  a_door_open_off:
    assert property ($rose(DOOR_OPEN[0]) |=> !PORT_POWER[0] &&
      !LED_PORT_POWER[0] && !LED_HOTPLUG[0]) else $error("door open");
  a_door_close_on:
    assert property ($fell(DOOR_OPEN[0]) |=> PORT_POWER[0] &&
      LED_PORT_POWER[0] && LED_DIMM_FAIL[7:0] == 8'h00) else $error("close");
  a_off_port_idle:
    assert property (!PORT_POWER[0] |-> !PORT_REQ[0].valid)
      else $error("request on dead port");
  a_req_held:
    assert property (PORT_REQ[0].valid && !PORT_READY[0] && !DOOR_OPEN[0]
      |=> $stable(PORT_REQ[0])) else $error("request moved");
  a_check_bits:
    assert property (PORT_REQ[1].valid && PORT_REQ[1].write |->
      PORT_REQ[1].word.check == chk(PORT_REQ[1].word.data))
      else $error("check bits");
  a_alert_lamp:
    assert property (PREDICTIVE_FAILURE_ALERT |=> !PREDICTIVE_FAILURE_ALERT
      && LED_DIMM_FAIL != 16'h0000) else $error("alert");
  a_err_with_ack:
    assert property (HOST_ERR |-> HOST_ACK ##1 !HOST_ACK)
      else $error("host error");
  c_close: cover property ($fell(DOOR_OPEN[0]));
  c_alert: cover property (PREDICTIVE_FAILURE_ALERT);
  c_err: cover property (HOST_ERR);
endmodule : mmp_properties

// [testbench/mmp_port_model.sv]
// Behavioural model of the two buffered memory ports.
`timescale 1ns/1ps
module mmp_port_model
  import mmp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Port traffic.
  input wire mmp_preq_type [1:0] req,
  output logic [1:0] ready,
  output mmp_presp_type [1:0] resp,
  // Pacing and fault injection on port one data.
  input wire logic slow,
  input wire logic [63:0] flip
);
  // ==========
  // Storage.
  mmp_word_type mem [2][16];
  logic tick;
  assign ready = slow ? {2{tick}} : 2'b11;
  // Idle response words are inverted each cycle so stale data never passes.
  always @(posedge clk) begin
    tick <= reset ? 1'b0 : !tick;
    for (int p = 0; p < 2; p++) begin
      resp[p].valid <= 1'b0;
      resp[p].word <= reset ? '0 : ~resp[p].word;
      if (reset)
        for (int a = 0; a < 16; a++) mem[p][a] <= '0;
      else if (req[p].valid && ready[p] && req[p].write)
        mem[p][req[p].addr[3:0]] <= req[p].word;
      else if (req[p].valid && ready[p]) begin
        resp[p].valid <= 1'b1;
        resp[p].word <= mem[p][req[p].addr[3:0]] ^
          (p == 0 ? 72'(flip) : 72'h0);
      end
    end
  end
endmodule : mmp_port_model

// [testbench/testbench.sv]
// Self-checking bench for the mirrored memory port controller.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module testbench
  import mmp_pkg::*;
;
  // ==========
  // Stimulus and wiring.
  logic clk = 1'b0, reset = 1'b1, av_rd = 1'b0, av_wr = 1'b0, slow = 1'b0;
  logic h_valid = 1'b0, h_write = 1'b0, he, av_wait, h_ack, h_err, alert;
  logic [7:0] av_addr = 8'h00;
  logic [31:0] av_wdata = 32'h0, h_addr = 32'h0, rd, av_rdata;
  logic [63:0] h_wdata = 64'h0, flip = 64'h0, hr, h_rdata;
  logic [63:0] d1 = 64'h1234_5678_9ABC_DEF0;
  logic [1:0] door = 2'b00, rdy, pwr, led_pwr, led_hp;
  logic [15:0] led_dimm;
  mmp_preq_type [1:0] preq;
  mmp_presp_type [1:0] presp;
  int fails = 0, n_tests = 0, cyc = 0, alerts = 0, n;
  mmp_controller #(.SCRUB_GAP(2), .TEST_WORDS(4), .BLINK_CYC(4))
    mmp_controller_i (.CLK(clk), .RESET(reset), .AVS_ADDRESS(av_addr),
    .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(av_rdata),
    .AVS_WAITREQUEST(av_wait), .HOST_VALID(h_valid), .HOST_WRITE(h_write),
    .HOST_ADDR(h_addr), .HOST_WDATA(h_wdata), .HOST_ACK(h_ack),
    .HOST_ERR(h_err), .HOST_RDATA(h_rdata), .PORT_REQ(preq),
    .PORT_READY(rdy), .PORT_RESP(presp), .DOOR_OPEN(door),
    .PORT_POWER(pwr), .LED_PORT_POWER(led_pwr), .LED_HOTPLUG(led_hp),
    .LED_DIMM_FAIL(led_dimm), .PREDICTIVE_FAILURE_ALERT(alert));
  mmp_port_model mmp_port_model_i (.clk(clk), .reset(reset), .req(preq),
    .ready(rdy), .resp(presp), .slow(slow), .flip(flip));
  initial begin
    forever #50 clk = ~clk;
  end
  // The ceiling is several times the expected run, so a hang ends quickly.
  always @(posedge clk) begin
    cyc++;
    alerts += int'(alert === 1'b1);
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic av(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    // Outputs are read mid-cycle, where they have settled.
    do @(negedge clk); while (av_wait !== 1'b0);
    rd = av_rdata;
    @(posedge clk);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic host(input logic wr, input logic [31:0] a,
    input logic [63:0] d);
    h_write <= wr;
    h_addr <= a;
    h_wdata <= d;
    h_valid <= 1'b1;
    do @(negedge clk); while (h_ack !== 1'b1);
    he = h_err;
    hr = h_rdata;
    @(posedge clk);
    h_valid <= 1'b0;
    @(posedge clk);
  endtask : host
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    av(0, 8'h04, 0);
    `CHK(rd & 32'hFFFF_FFFD, 32'h0000_000C)
    av(0, 8'h1C, 0);
    `CHK(rd, 32'h0)
    av(1, 8'h08, 16);
    av(1, 8'h0C, 8);
    av(1, 8'h00, 1);
    av(0, 8'h04, 0);
    `CHK(rd[0], 1'b0)
    av(1, 8'h00, 3);
    av(0, 8'h04, 0);
    `CHK(rd[0], 1'b1)
    slow <= 1'b1;
    host(1, 3, d1);
    host(1, 12, ~d1);
    `CHK(mmp_port_model_i.mem[0][3].data, d1)
    `CHK(mmp_port_model_i.mem[1][3].data, d1)
    `CHK(mmp_port_model_i.mem[1][12].data, 64'h0)
    host(1, 16, d1);
    `CHK(he, 1'b1)
    slow <= 1'b0;
    door <= 2'b01;
    repeat (3) @(posedge clk);
    `CHK({pwr[0], led_pwr[0], led_hp[0]}, 3'b000)
    host(0, 3, 0);
    `CHK({he, hr}, {1'b0, d1})
    door <= 2'b00;
    n = 0;
    repeat (30) begin
      @(negedge clk);
      n += int'(led_hp[0] === 1'b1);
    end
    `CHK(n inside {[1:29]}, 1'b1)
    repeat (200) @(posedge clk);
    `CHK({pwr[0], led_pwr[0]}, 2'b11)
    `CHK(mmp_port_model_i.mem[0][3].data, d1)
    repeat (6) begin
      @(negedge clk);
      `CHK(led_hp[0], 1'b1)
    end
    av(1, 8'h00, 5);
    flip <= 64'h10;
    repeat (100) @(posedge clk);
    `CHK({alerts, led_dimm}, {32'h0, 16'h0})
    av(0, 8'h10, 0);
    `CHK(rd[7:2], 6'h22)
    host(0, 3, 0);
    `CHK(hr, d1)
    flip <= 64'h410;
    repeat (100) @(posedge clk);
    `CHK(alerts != 0, 1'b1)
    `CHK({led_dimm[15:8], led_dimm[7:0] != 0}, 9'h001)
    host(0, 3, 0);
    `CHK({he, hr}, {1'b0, d1})
    av(0, 8'h04, 0);
    `CHK(rd[4], 1'b0)
    flip <= 64'h1410;
    repeat (100) @(posedge clk);
    av(0, 8'h04, 0);
    `CHK(rd[4], 1'b1)
    host(0, 3, 0);
    `CHK({he, hr}, {1'b0, d1})
    report_and_stop();
  end
endmodule : testbench
bind mmp_controller mmp_properties mmp_properties_i (.CLK, .RESET, .AVS_READ,
  .AVS_WRITE, .AVS_WAITREQUEST, .HOST_ACK, .HOST_ERR, .PORT_REQ, .PORT_READY,
  .DOOR_OPEN, .PORT_POWER, .LED_PORT_POWER, .LED_HOTPLUG, .LED_DIMM_FAIL,
  .PREDICTIVE_FAILURE_ALERT);
